// >>> hdl/tap_sequencer.sv
// Line control sequencer: addressing, polling and answerback replies
`timescale 1ns/10ps
module tap_sequencer
	import tap_pkg::*;
#(
	parameter logic [6:0] CTL_RECV = CTL_RECV_CODE,
	parameter logic [6:0] ADDR_SEL = ADDR_SEL_CODE,
	parameter logic [6:0] TEXT_GO = TEXT_GO_CODE,
	parameter logic [6:0] SPACE = SPACE_CODE,
	parameter logic [6:0] ALLCALL = ALLCALL_CODE,
	parameter logic [6:0] START = START_CODE,
	parameter logic [6:0] YES = YES_CODE,
	parameter logic [6:0] NO = NO_CODE
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Received characters from the deserializer, same clock
	input wire logic rx_valid,
	input wire logic [6:0] rx_char,
	// Station configuration
	input wire logic [6:0] station_addr,
	input wire logic [6:0] group_addr,
	input wire logic allcall_master,
	input wire logic has_status,
	input wire logic recv_status,
	// Operator and status pins, asynchronous
	input wire logic bid_key,
	input wire logic no_paper,
	input wire logic insert_down,
	input wire logic local_mode,
	input wire logic buf_print,
	input wire logic enter_key,
	input wire logic status_inhibit,
	input wire logic elec_err,
	input wire logic io_err,
	input wire logic rx_par_err,
	input wire logic tx_par_err,
	// Characters to the serializer
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [6:0] tx_char,
	// Line and operator outputs
	output logic send,
	output logic serdes_clk_run,
	output logic alarm_bell,
	output logic end_answerback,
	// Observable state
	output tap_mode_type mode,
	output logic master_flag,
	output logic end_of_state_latch,
	output logic first_status_latch,
	output logic second_status_latch,
	output logic [6:0] char_buffer_reg
);

	tap_mode_type mode_q;
	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] s1_q;
	logic [PIN_N-1:0] s2_q;
	logic [PIN_N-1:0] s3_q;
	logic [PIN_N-1:0] pin_q;
	logic master_q;
	logic recv_text_q;
	logic addr_sel_q;
	logic yes_q;
	logic first_q;
	logic second_q;
	logic eos_q;
	logic ph1_q;
	logic ph2_q;
	logic buf_full_q;
	logic pushed_q;
	logic start_sent_q;
	logic bell_q;
	logic end_q;
	logic [6:0] buf_q;
	logic [6:0] sense_char;
	logic [6:0] load_char;
	logic any_err;
	logic rx_ctl;
	logic latch_busy;
	logic answering;
	logic chain_start;
	logic push_ok;
	logic buf_reset;
	logic end_ans;
	logic fifo_ready;
	logic fifo_empty;
	logic enter_tsa;

	// Pins gathered so one synchroniser serves them all
	assign pin_raw = {tx_par_err, rx_par_err, io_err, elec_err, status_inhibit,
		enter_key, buf_print, local_mode, insert_down, no_paper, bid_key};

	// Three-stage synchroniser; stage one feeds only stage two
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= PINS_RST;
			s2_q <= PINS_RST;
			s3_q <= PINS_RST;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a pin change only once two stages agree, filtering glitches
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_q <= PINS_RST;
		end else begin
			for (int i = 0; i < PIN_N; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					pin_q[i] <= s3_q[i];
				end
			end
		end
	end

	// Sense character; busy bits or stored errors
	always_comb begin
		sense_char = CHAR_RST;
		any_err = pin_q[PIN_ELEC_ERR] || pin_q[PIN_IO_ERR] || pin_q[PIN_RX_PAR] ||
			pin_q[PIN_TX_PAR];
		if (recv_status) begin
			if (!any_err) begin
				sense_char = SPACE;
			end else begin
				sense_char[BIT_A] = 1'b1;
				sense_char[BIT_C] = 1'b1;
				sense_char[BIT_1] = pin_q[PIN_ELEC_ERR];
				sense_char[BIT_2] = pin_q[PIN_IO_ERR];
				sense_char[BIT_4] = pin_q[PIN_RX_PAR];
				sense_char[BIT_8] = pin_q[PIN_TX_PAR];
			end
		end else if (!pin_q[PIN_INHIBIT]) begin
			sense_char[BIT_2] = pin_q[PIN_BID];
			sense_char[BIT_1] = pin_q[PIN_NO_PAPER] || pin_q[PIN_ENTER];
			sense_char[BIT_8] = pin_q[PIN_NO_PAPER] || pin_q[PIN_LOCAL];
			sense_char[BIT_C] = pin_q[PIN_NO_PAPER];
			sense_char[BIT_A] = pin_q[PIN_INS_DOWN];
			sense_char[BIT_4] = pin_q[PIN_BUF_PRINT];
		end
	end

	// Character chosen at the phase-two load
	always_comb begin
		load_char = NO;
		if (mode_q == MODE_TT) begin
			load_char = START;
		end else if (mode_q == MODE_TSA && first_q && !second_q) begin
			load_char = sense_char;
		end else if (mode_q == MODE_TSA && second_q) begin
			load_char = yes_q ? YES : NO;
		end
	end

	// Decodes shared by the processes below
	assign rx_ctl = rx_valid && (rx_char == CTL_RECV);
	assign latch_busy = first_q || second_q;
	assign enter_tsa = rx_valid && !latch_busy && mode_q == MODE_CAS && rx_char == SPACE &&
		master_q;
	assign answering = (mode_q == MODE_TSA && master_q && !recv_text_q) ||
		(mode_q == MODE_TPA && !master_q) ||
		(mode_q == MODE_TT && !start_sent_q);
	assign chain_start = answering && !ph2_q && !ph1_q && !buf_full_q && !eos_q;
	assign push_ok = buf_full_q && !pushed_q && fifo_ready;
	// Reset after the sense character left, between the two characters, or after the start character in MODE_TT
	assign buf_reset = eos_q && pushed_q && !push_ok && (first_q || mode_q == MODE_TT);
	assign end_ans = eos_q && !latch_busy && fifo_empty && buf_full_q &&
		(mode_q == MODE_TSA || mode_q == MODE_TPA);

	// Mode sequencing; latches block every change while set
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= MODE_TNS;
		end else if (end_ans) begin
			if (mode_q == MODE_TPA) begin
				mode_q <= MODE_CR;
			end else begin
				mode_q <= yes_q ? MODE_CS : MODE_CA;
			end
		end else if (rx_valid && !latch_busy) begin
			case (mode_q)
				MODE_TNS: begin
					if (rx_ctl) begin
						mode_q <= MODE_CR;
					end
				end
				MODE_CR: begin
					if (rx_char == ADDR_SEL) begin
						mode_q <= MODE_CA;
					end else if (rx_char == station_addr) begin
						mode_q <= MODE_IP;
					end
				end
				MODE_CA: begin
					if (rx_ctl) begin
						mode_q <= MODE_CR;
					end else if (rx_char == TEXT_GO) begin
						mode_q <= MODE_TNS;
					end else if (rx_char == station_addr || rx_char == group_addr ||
						rx_char == ALLCALL) begin
						mode_q <= MODE_CAS;
					end
				end
				MODE_CAS: begin
					if (enter_tsa) begin
						mode_q <= MODE_TSA;
					end else if (rx_ctl) begin
						mode_q <= MODE_CR;
					end else if (rx_char == TEXT_GO) begin
						mode_q <= MODE_TNS;
					end
				end
				MODE_CS: begin
					if (rx_char == TEXT_GO) begin
						mode_q <= MODE_RT;
					end else if (rx_ctl) begin
						mode_q <= MODE_CR;
					end
				end
				MODE_IP: begin
					if (rx_ctl) begin
						mode_q <= MODE_CR;
					end else if (rx_char == SPACE) begin
						mode_q <= pin_q[PIN_BID] ? MODE_TT : MODE_TPA;
					end else begin
						mode_q <= MODE_TNS;
					end
				end
				MODE_RT: begin
					if (rx_ctl) begin
						mode_q <= MODE_CR;
					end
				end
				default: begin
					mode_q <= mode_q;
				end
			endcase
		end
	end

	// Mode flip-flops: master, receive text, address selected
	always_ff @(posedge clk) begin
		if (rst) begin
			master_q <= 1'b0;
			recv_text_q <= 1'b0;
			addr_sel_q <= 1'b0;
		end else if (end_ans && mode_q == MODE_TPA) begin
			// Poll reply done: back in control receive, so the mode flags follow
			master_q <= 1'b1;
			recv_text_q <= 1'b0;
			addr_sel_q <= 1'b0;
		end else if (rx_valid && !latch_busy && !end_ans) begin
			if (rx_ctl && mode_q != MODE_TSA && mode_q != MODE_TPA && mode_q != MODE_TT) begin
				master_q <= 1'b1;
				recv_text_q <= 1'b0;
				addr_sel_q <= 1'b0;
			end else if (mode_q == MODE_CA && rx_char == station_addr) begin
				addr_sel_q <= 1'b1; // Own address always answers as master
			end else if (mode_q == MODE_CA && (rx_char == group_addr || rx_char == ALLCALL)) begin
				addr_sel_q <= 1'b1;
				master_q <= allcall_master;
			end else if (mode_q == MODE_CS && rx_char == TEXT_GO) begin
				recv_text_q <= 1'b1;
			end else if (mode_q == MODE_IP && rx_char == SPACE) begin
				master_q <= 1'b0;
			end
		end
	end

	// Reply decision and the bell, caught at entry to status answerback
	always_ff @(posedge clk) begin
		if (rst) begin
			yes_q <= 1'b0;
			bell_q <= 1'b0;
		end else begin
			bell_q <= enter_tsa && !has_status;
			if (enter_tsa) begin
				yes_q <= has_status;
			end
		end
	end

	// First and second status character latches
	always_ff @(posedge clk) begin
		if (rst) begin
			first_q <= 1'b0;
			second_q <= 1'b0;
		end else begin
			if (enter_tsa) begin
				first_q <= 1'b1;
			end else if (ph1_q && second_q) begin
				first_q <= 1'b0;
			end
			if (buf_reset && first_q) begin
				second_q <= 1'b1;
			end else if (push_ok && second_q && !first_q) begin
				second_q <= 1'b0;
			end
		end
	end

	// Control clock chain; phase two marks the buffer load
	always_ff @(posedge clk) begin
		if (rst) begin
			ph1_q <= 1'b0;
			ph2_q <= 1'b0;
		end else begin
			ph1_q <= chain_start;
			ph2_q <= ph1_q;
		end
	end

	// Character buffer; end-of-state holds it until the reply has gone
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_q <= CHAR_RST;
			buf_full_q <= 1'b0;
			pushed_q <= 1'b0;
			eos_q <= 1'b0;
			start_sent_q <= 1'b0;
		end else if (end_ans || buf_reset) begin
			buf_q <= CHAR_RST;
			buf_full_q <= 1'b0;
			pushed_q <= 1'b0;
			eos_q <= 1'b0;
			start_sent_q <= start_sent_q || mode_q == MODE_TT;
		end else begin
			if (ph2_q) begin
				buf_q <= load_char;
				buf_full_q <= 1'b1;
			end
			if (push_ok) begin
				pushed_q <= 1'b1;
				eos_q <= 1'b1;
			end
			if (mode_q != MODE_TT) begin
				start_sent_q <= 1'b0;
			end
		end
	end

	// End pulse to the host side, one cycle per finished answerback
	always_ff @(posedge clk) begin
		if (rst) begin
			end_q <= 1'b0;
		end else begin
			end_q <= end_ans;
		end
	end

	// Shift register side; a stall there simply holds the buffer
	tap_pair_buf #(
		.WIDTH(CHAR_W)
	) u_pair_buf (
		.clk(clk),
		.rst(rst),
		.in_valid(buf_full_q && !pushed_q),
		.in_ready(fifo_ready),
		.in_data(buf_q),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_char),
		.empty(fifo_empty)
	);

	// Transmit modes drive the line and keep the serializer clock running
	assign send = (mode_q == MODE_TSA) || (mode_q == MODE_TPA) || (mode_q == MODE_TT);
	assign serdes_clk_run = send;
	assign alarm_bell = bell_q;
	assign end_answerback = end_q;
	assign mode = mode_q;
	assign master_flag = master_q;
	assign end_of_state_latch = eos_q;
	assign first_status_latch = first_q;
	assign second_status_latch = second_q;
	assign char_buffer_reg = buf_q;

endmodule

// >>> hdl/tap_pkg.sv
// Shared constants and types for the terminal answerback and polling sequencer
package tap_pkg;

	// Character width and bit positions (1 2 4 8 A B C)
	localparam int CHAR_W = 7;
	localparam int BIT_1 = 0;
	localparam int BIT_2 = 1;
	localparam int BIT_4 = 2;
	localparam int BIT_8 = 3;
	localparam int BIT_A = 4;
	localparam int BIT_B = 5;
	localparam int BIT_C = 6;

	// Default control character codes, overridable per line discipline
	localparam logic [6:0] CTL_RECV_CODE = 7'h7c;
	localparam logic [6:0] ADDR_SEL_CODE = 7'h62;
	localparam logic [6:0] TEXT_GO_CODE = 7'h54;
	localparam logic [6:0] SPACE_CODE = 7'h40;
	localparam logic [6:0] ALLCALL_CODE = 7'h31;
	localparam logic [6:0] START_CODE = 7'h1e;
	localparam logic [6:0] YES_CODE = 7'h7f;
	localparam logic [6:0] NO_CODE = 7'h20;

	// Reset values
	localparam logic [6:0] CHAR_RST = 7'h00;
	localparam logic [10:0] PINS_RST = 11'h000;

	// Pin vector positions after synchronising
	localparam int PIN_BID = 0;
	localparam int PIN_NO_PAPER = 1;
	localparam int PIN_INS_DOWN = 2;
	localparam int PIN_LOCAL = 3;
	localparam int PIN_BUF_PRINT = 4;
	localparam int PIN_ENTER = 5;
	localparam int PIN_INHIBIT = 6;
	localparam int PIN_ELEC_ERR = 7;
	localparam int PIN_IO_ERR = 8;
	localparam int PIN_RX_PAR = 9;
	localparam int PIN_TX_PAR = 10;
	localparam int PIN_N = 11;

	// Line control modes
	typedef enum logic [3:0] {
		MODE_TNS = 4'h0,
		MODE_CR = 4'h1,
		MODE_CA = 4'h2,
		MODE_CAS = 4'h3,
		MODE_TSA = 4'h4,
		MODE_CS = 4'h5,
		MODE_RT = 4'h6,
		MODE_IP = 4'h7,
		MODE_TT = 4'h8,
		MODE_TPA = 4'h9
	} tap_mode_type;

endpackage

// >>> hdl/tap_pair_buf.sv
// Two-entry valid/ready buffer between the character buffer and the serializer
`timescale 1ns/10ps
module tap_pair_buf #(
	parameter int WIDTH = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Occupancy
	output logic empty
);

	logic [WIDTH-1:0] slot_q [2];
	logic [1:0] count_q;
	logic rd_q;
	logic wr_q;
	logic do_push;
	logic do_pop;

	// Handshakes are combinational so the source stalls the same cycle
	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign empty = (count_q == 2'h0);
	assign out_data = slot_q[rd_q];
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;

	// Storage slots, written by index
	always_ff @(posedge clk) begin
		if (rst) begin
			slot_q[0] <= '0;
			slot_q[1] <= '0;
		end else if (do_push) begin
			slot_q[wr_q] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (do_push) begin
				wr_q <= ~wr_q;
			end
			if (do_pop) begin
				rd_q <= ~rd_q;
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + 2'h1;
			end else if (do_pop && !do_push) begin
				count_q <= count_q - 2'h1;
			end
		end
	end

endmodule

// >>> tb/tap_seq_chk.sv
// Concurrent checks on the sequencer's ports
`timescale 1ns/10ps
module tap_seq_chk
	import tap_pkg::*;
#(
	parameter logic [6:0] SPACE = SPACE_CODE
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Inputs watched
	input wire logic rx_valid,
	input wire logic [6:0] rx_char,
	input wire logic [6:0] station_addr,
	input wire logic has_status,
	input wire logic tx_ready,
	// Outputs watched
	input wire logic tx_valid,
	input wire logic [6:0] tx_char,
	input wire logic send,
	input wire logic serdes_clk_run,
	input wire logic alarm_bell,
	input wire logic end_answerback,
	input wire tap_mode_type mode,
	input wire logic master_flag,
	input wire logic end_of_state_latch,
	input wire logic first_status_latch,
	input wire logic second_status_latch
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic in_ans;
	logic xmit;
	// Answerback and transmit mode groups
	assign in_ans = (mode == MODE_TSA) || (mode == MODE_TPA);
	assign xmit = in_ans || (mode == MODE_TT);
	sequence s_leave;
		$past(in_ans) && !in_ans;
	endsequence
	sequence s_space_cas;
		rx_valid && rx_char == SPACE && mode == MODE_CAS && master_flag;
	endsequence
	a_send_mode: assert property (send == xmit && serdes_clk_run == xmit)
		else $error("send or serdes clock wrong for mode");
	a_bell_pulse: assert property ($rose(alarm_bell) |-> mode == MODE_TSA && !has_status ##1 !alarm_bell)
		else $error("bell pulse wrong");
	a_first_set: assert property (s_space_cas |=> first_status_latch && mode == MODE_TSA)
		else $error("space in selected did not start answerback");
	a_second_cause: assert property ($rose(second_status_latch) |-> $past(first_status_latch) && $past(end_of_state_latch))
		else $error("second latch set without cause");
	a_latch_lock: assert property (second_status_latch |=> mode == MODE_TSA)
		else $error("mode changed while status latch busy");
	a_end_pulse: assert property (s_leave |-> ##[0:1] end_answerback)
		else $error("no end of answerback pulse");
	a_end_cause: assert property (end_answerback |-> !first_status_latch && !second_status_latch)
		else $error("end of answerback with latch set");
	a_cr_master: assert property (mode == MODE_CR && $past(mode) != MODE_CR |-> master_flag)
		else $error("control receive without master flag");
	a_ip_entry: assert property (rx_valid && mode == MODE_CR && rx_char == station_addr |=> mode == MODE_IP)
		else $error("station address did not enter polling");
	a_tpa_slave: assert property (mode == MODE_TPA |-> !master_flag)
		else $error("poll answerback with master flag");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
		else $error("stalled character lost");
endmodule
bind tap_sequencer tap_seq_chk #(.SPACE(SPACE)) u_chk (.clk(clk), .rst(rst), .rx_valid(rx_valid),
	.rx_char(rx_char), .station_addr(station_addr), .has_status(has_status), .tx_ready(tx_ready),
	.tx_valid(tx_valid), .tx_char(tx_char), .send(send), .serdes_clk_run(serdes_clk_run),
	.alarm_bell(alarm_bell), .end_answerback(end_answerback), .mode(mode),
	.master_flag(master_flag), .end_of_state_latch(end_of_state_latch),
	.first_status_latch(first_status_latch), .second_status_latch(second_status_latch));

// >>> tb/tap_line_mux.sv
// Line multiplexer model taking reply characters from the sequencer
`timescale 1ns/10ps
module tap_line_mux (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Character stream
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [6:0] tx_char,
	// Pacing
	input wire logic slow
);
	logic tog_q;
	logic [6:0] got [0:7];
	int n;
	// Slow pacing takes every other cycle, so the buffer must hold a stalled word
	assign tx_ready = !slow || tog_q;
	// Record each character taken, in order
	always_ff @(posedge clk) begin
		if (rst) begin
			tog_q <= 1'b0;
			n <= 0;
		end else begin
			tog_q <= !tog_q;
			if (tx_valid && tx_ready) begin
				got[n[2:0]] <= tx_char;
				n <= n + 1;
			end
		end
	end
endmodule

// >>> tb/terminal_answerback_polling_bench.sv
// Self-checking bench for the answerback and polling sequencer
`timescale 1ns/10ps
module terminal_answerback_polling_bench;
	import tap_pkg::*;
	localparam logic [6:0] STN = 7'h23;
	logic clk, rst, rx_valid, slow, has_status, recv_status, alm;
	logic tx_valid, tx_ready, send, serdes_clk_run, alarm_bell, end_answerback;
	logic master_flag, end_of_state_latch, first_status_latch, second_status_latch;
	logic [6:0] rx_char, tx_char, char_buffer_reg;
	logic [10:0] pins;
	tap_mode_type mode;
	int err_total, num_checks, ends, bells;
	`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
		$display("MISMATCH %s exp %h got %h", nm, e, g); end end
	tap_sequencer u_dut (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_char(rx_char),
		.station_addr(STN), .group_addr(7'h24), .allcall_master(alm), .has_status(has_status),
		.recv_status(recv_status), .bid_key(pins[PIN_BID]), .no_paper(pins[PIN_NO_PAPER]),
		.insert_down(pins[PIN_INS_DOWN]), .local_mode(pins[PIN_LOCAL]),
		.buf_print(pins[PIN_BUF_PRINT]), .enter_key(pins[PIN_ENTER]),
		.status_inhibit(pins[PIN_INHIBIT]), .elec_err(pins[PIN_ELEC_ERR]),
		.io_err(pins[PIN_IO_ERR]), .rx_par_err(pins[PIN_RX_PAR]), .tx_par_err(pins[PIN_TX_PAR]),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char), .send(send),
		.serdes_clk_run(serdes_clk_run), .alarm_bell(alarm_bell), .end_answerback(end_answerback),
		.mode(mode), .master_flag(master_flag), .end_of_state_latch(end_of_state_latch),
		.first_status_latch(first_status_latch), .second_status_latch(second_status_latch),
		.char_buffer_reg(char_buffer_reg));
	tap_line_mux u_mux (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_char(tx_char), .slow(slow));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Count one-cycle pulses mid-cycle, away from the edge that launches them
	always @(negedge clk) begin
		if (end_answerback === 1'b1) ends++;
		if (alarm_bell === 1'b1) bells++;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Inputs always move 10 ns after the rising edge
	task automatic step(int k);
		repeat (k) @(posedge clk);
		#10;
	endtask
	task automatic rx(logic [6:0] c);
		rx_valid = 1'b1;
		rx_char = c;
		step(1);
		rx_valid = 1'b0;
		step(1);
	endtask
	task automatic wait_mode(tap_mode_type m);
		for (int i = 0; i < 300 && mode !== m; i++) step(1);
		if (mode !== m) begin
			err_total++;
			$display("MISMATCH wait mode exp %h got %h", m, mode);
			results();
		end
	endtask
	// Two edges of reset, then time for the pin filters to settle
	task automatic do_reset;
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		ends = 0;
		bells = 0;
		step(6);
		`CHK("mode after reset", MODE_TNS, mode)
	endtask
	// Full addressing run; the codes come from the package, not from the design
	task automatic addr_flow(logic [6:0] sense, logic [6:0] second, tap_mode_type fin, int bell);
		do_reset();
		rx(CTL_RECV_CODE);
		`CHK("mode cr", MODE_CR, mode)
		`CHK("master", 1'b1, master_flag)
		rx(ADDR_SEL_CODE);
		`CHK("mode ca", MODE_CA, mode)
		rx(STN);
		`CHK("mode cas", MODE_CAS, mode)
		rx(SPACE_CODE);
		`CHK("mode tsa", MODE_TSA, mode)
		`CHK("send", 1'b1, send)
		`CHK("first latch", 1'b1, first_status_latch)
		wait_mode(fin);
		`CHK("buffer cleared", 7'h00, char_buffer_reg)
		step(2);
		`CHK("reply count", 2, u_mux.n)
		`CHK("sense char", sense, u_mux.got[0])
		`CHK("second char", second, u_mux.got[1])
		`CHK("end pulses", 1, ends)
		`CHK("bell pulses", bell, bells)
	endtask
	task automatic t_busy;
		int bp[7] = '{PIN_BID, PIN_NO_PAPER, PIN_INS_DOWN, PIN_LOCAL, PIN_BUF_PRINT, PIN_ENTER,
			PIN_INHIBIT};
		logic [6:0] be[7] = '{7'h02, 7'h49, 7'h10, 7'h08, 7'h04, 7'h01, 7'h00};
		has_status = 1'b1;
		recv_status = 1'b0;
		for (int i = 0; i < 7; i++) begin
			pins = 11'h000;
			pins[bp[i]] = 1'b1;
			if (i == 6) pins[PIN_LOCAL] = 1'b1;
			slow = i[0];
			addr_flow(be[i], YES_CODE, MODE_CS, 0);
		end
		$display("test busy done, mismatches %0d", err_total);
	endtask
	task automatic t_errs;
		int ep[4] = '{PIN_ELEC_ERR, PIN_IO_ERR, PIN_RX_PAR, PIN_TX_PAR};
		logic [6:0] ee[4] = '{7'h51, 7'h52, 7'h54, 7'h58};
		has_status = 1'b0;
		recv_status = 1'b1;
		for (int i = 0; i < 4; i++) begin
			pins = 11'h000;
			pins[ep[i]] = 1'b1;
			slow = i[0];
			addr_flow(ee[i], NO_CODE, MODE_CA, 1);
		end
		$display("test errors done, mismatches %0d", err_total);
	endtask
	task automatic t_poll_no;
		pins = 11'h000;
		slow = 1'b1;
		do_reset();
		rx(CTL_RECV_CODE);
		rx(STN);
		`CHK("mode ip", MODE_IP, mode)
		rx(SPACE_CODE);
		`CHK("mode tpa", MODE_TPA, mode)
		`CHK("slave in tpa", 1'b0, master_flag)
		wait_mode(MODE_CR);
		`CHK("poll reply count", 1, u_mux.n)
		`CHK("poll reply", NO_CODE, u_mux.got[0])
		step(1);
		`CHK("poll end pulse", 1, ends)
		$display("test poll no bid done, mismatches %0d", err_total);
	endtask
	task automatic t_poll_bid;
		pins = 11'h000;
		pins[PIN_BID] = 1'b1;
		slow = 1'b0;
		do_reset();
		rx(CTL_RECV_CODE);
		rx(STN);
		rx(SPACE_CODE);
		wait_mode(MODE_TT);
		for (int i = 0; i < 50 && u_mux.n < 1; i++) step(1);
		if (u_mux.n < 1) begin
			err_total++;
			$display("MISMATCH start wait exp 1 got 0");
			results();
		end
		`CHK("start char", START_CODE, u_mux.got[0])
		$display("test poll bid done, mismatches %0d", err_total);
	endtask
	task automatic t_ip_exit;
		pins = 11'h000;
		do_reset();
		rx(CTL_RECV_CODE);
		rx(STN);
		rx(CTL_RECV_CODE);
		`CHK("ip to cr", MODE_CR, mode)
		rx(STN);
		rx(ADDR_SEL_CODE);
		`CHK("ip to tns", MODE_TNS, mode)
		$display("test polling exits done, mismatches %0d", err_total);
	endtask
	// Group address without the master jumper: slave ignores the space
	task automatic t_slave;
		pins = 11'h000;
		alm = 1'b0;
		do_reset();
		rx(CTL_RECV_CODE);
		rx(ADDR_SEL_CODE);
		rx(7'h24);
		`CHK("slave cas", MODE_CAS, mode)
		`CHK("slave master", 1'b0, master_flag)
		rx(SPACE_CODE);
		`CHK("slave first latch", 1'b0, first_status_latch)
		`CHK("slave stays cas", MODE_CAS, mode)
		`CHK("slave no send", 1'b0, send)
		alm = 1'b1;
		$display("test slave done, mismatches %0d", err_total);
	endtask
	initial begin
		rst = 1'b1;
		rx_valid = 1'b0;
		rx_char = 7'h00;
		pins = 11'h000;
		has_status = 1'b1;
		recv_status = 1'b0;
		slow = 1'b0;
		alm = 1'b1;
		err_total = 0;
		num_checks = 0;
		t_busy();
		t_errs();
		t_poll_no();
		t_poll_bid();
		t_ip_exit();
		t_slave();
		results();
	end
endmodule
